// File: uepo_pkg.sv
// Summary of operation
// R01: Endpoint flags active only for bulk/interrupt
// R02: Good packet sets receive ready, locks
// R03: Write one clears receive ready, unlocks
// R04: Write one sets transmit ready, enables
// R05: Host ACK clears transmit ready, locks
// R06: Upper status bits zero; both resets clear
// R07: Four read-only error flags, upper zero
// R08: Start of packet clears error flags
// R09: Bus reset keeps oscillator bits
// R10: Control zero powers down oscillator, PLL
// R11: Control honoured only while enable set
// R12: Enable bit permits or blocks control
// R13: Stop needs select flag and stop/subclock
// R14: Oscillator runs while processor needs it
// R15: Core reset flag cleared, firmware releases
// R16: Locked endpoint answers NAK
// R17: Zero writes and error writes ignored
package uepo_pkg;
  localparam logic [15:0] uepo_usb_packet_error_flags_addr = 16'h1a39;
  localparam logic [15:0] uepo_oscillator_powerdown_test_addr = 16'h1a3a;
  localparam logic [15:0] uepo_endpoint_three_status_addr = 16'h1a63;
  localparam logic [15:0] uepo_ctrl_addr = 16'h1a40;
  localparam logic [15:0] uepo_irq_stat_addr = 16'h1a44;
  localparam logic [15:0] uepo_irq_mask_addr = 16'h1a48;
  localparam int uepo_rx_rdy_bit = 0;
  localparam int uepo_tx_rdy_bit = 1;
  localparam int uepo_pd_ctl_bit = 1;
  localparam int uepo_pd_en_bit = 2;
  localparam int uepo_core_rst_bit = 0;
  localparam int uepo_err_stuff_bit = 0;
  localparam int uepo_err_dcrc_bit = 1;
  localparam int uepo_err_acrc_bit = 2;
  localparam int uepo_err_pid_bit = 3;
  localparam int uepo_irq_rx_bit = 0;
  localparam int uepo_irq_ack_bit = 1;
  localparam int uepo_irq_err_bit = 2;
  localparam logic [7:0] uepo_byte_reset = 8'h00;
  localparam logic [2:0] uepo_irq_reset = 3'h0;
  localparam logic [1:0] uepo_ep_bulk = 2'h2;
  localparam logic [1:0] uepo_ep_intr = 2'h3;
  typedef enum logic [1:0] {
    uepo_idle = 2'b00,
    uepo_ack = 2'b01,
    uepo_nak = 2'b10
  } uepo_hs_type;
endpackage

// File: uepo_osc_gate.sv
`timescale 1ns/1ps
`default_nettype none
module uepo_osc_gate (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic pd_enable, // Power down enable bit
  input wire logic pd_control, // Power down control bit
  input wire logic osc_select, // Standby osc select flag
  input wire logic cpu_stop, // Processor in stop mode
  input wire logic cpu_subclk, // Processor on subclock
  output logic osc_run // Oscillator and PLL run
);
  logic want_down;
  assign want_down = pd_enable && !pd_control; // R11 R12 R10
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run <= 1'b1;
    end else begin
      // Processor clock demand overrides the request
      osc_run <= !(want_down && osc_select && (cpu_stop || cpu_subclk)); // R13 R14
    end
  end
  a_osc_needed: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (!cpu_stop && !cpu_subclk) |=> osc_run)
    else $error("oscillator stopped while needed");
  a_osc_stop: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (pd_enable && !pd_control && osc_select && cpu_stop) |=> !osc_run)
    else $error("oscillator not stopped");
  a_osc_block: assert property (@(posedge pclk) disable iff (!presetn) // R12
    !pd_enable |=> osc_run)
    else $error("power down not blocked");
endmodule
`default_nettype wire

// File: uepo_top.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uepo_top (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [15:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic usb_bus_reset, // USB bus reset pulse
  input wire logic [1:0] ep3_type, // Endpoint three transfer type
  input wire logic rx_good, // Error-free OUT packet done
  input wire logic host_ack, // Host ACK for IN data
  input wire logic rx_token, // OUT data arriving for ep3
  input wire logic in_token, // IN token for ep3
  input wire logic sop_seen, // Start of packet pulse
  input wire logic [3:0] err_seen, // Stuff, dcrc, acrc, pid pulses
  input wire logic osc_select_pin, // Standby osc select, async
  input wire logic cpu_stop_pin, // Stop mode, async
  input wire logic cpu_subclk_pin, // Subclock running, async
  output logic [1:0] handshake, // Handshake code to packet engine
  output logic rx_enable, // Ep3 may accept data
  output logic tx_enable, // Ep3 may transmit
  output logic usb_core_rst_n, // USB core reset, active low
  output logic osc_run, // Oscillator and PLL run
  output logic irq // Interrupt, level high
);
  import uepo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic rx_rdy;
  logic tx_rdy;
  logic [3:0] err_flags;
  logic pd_en;
  logic pd_ctl;
  logic core_rel;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic ep_valid;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic [2:0] next_irq_stat;
  logic [31:0] next_prdata;
  logic known;

  // Register index to aligned word address; low bits must be zero
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == {r[13:0], 2'h0});
  endfunction

  assign ep_valid = (ep3_type == uepo_ep_bulk) || (ep3_type == uepo_ep_intr); // R01
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Level inputs from other clock domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {cpu_subclk_pin, cpu_stop_pin, osc_select_pin};
      sync_b <= sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint three ready flags; hardware event wins over firmware write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rdy <= 1'b0;
      tx_rdy <= 1'b0;
    end else if (usb_bus_reset) begin
      rx_rdy <= 1'b0; // R06
      tx_rdy <= 1'b0; // R06
    end else begin
      if (ep_valid && rx_good) begin
        rx_rdy <= 1'b1; // R02
      end else if (wr_acc && hit(paddr, uepo_endpoint_three_status_addr) && wbyte[uepo_rx_rdy_bit]) begin
        rx_rdy <= 1'b0; // R03 R17
      end
      if (ep_valid && host_ack) begin
        tx_rdy <= 1'b0; // R05
      end else if (wr_acc && hit(paddr, uepo_endpoint_three_status_addr) && wbyte[uepo_tx_rdy_bit]) begin
        tx_rdy <= 1'b1; // R04 R17
      end
    end
  end

  // Lock and handshake toward the packet engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      handshake <= uepo_idle;
    end else begin
      rx_enable <= ep_valid && !rx_rdy; // R03
      tx_enable <= ep_valid && tx_rdy; // R04
      if (ep_valid && ((rx_token && rx_rdy) || (in_token && !tx_rdy))) begin
        handshake <= uepo_nak; // R16
      end else if (ep_valid && rx_token) begin
        handshake <= uepo_ack;
      end else begin
        handshake <= uepo_idle;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags: SOP clears, but an error in the same cycle still lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flags <= 4'h0;
    end else if (usb_bus_reset) begin
      err_flags <= 4'h0;
    end else if (sop_seen) begin
      err_flags <= err_seen; // R08
    end else begin
      err_flags <= err_flags | err_seen; // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator test byte survives bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_en <= 1'b0; // R09
      pd_ctl <= 1'b0; // R09
    end else if (wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr)) begin
      pd_en <= wbyte[uepo_pd_en_bit]; // R12
      pd_ctl <= wbyte[uepo_pd_ctl_bit]; // R10
    end
  end

  // Core reset release flag; cleared by every system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rel <= 1'b0; // R15
      usb_core_rst_n <= 1'b0;
    end else begin
      if (wr_acc && hit(paddr, uepo_ctrl_addr)) begin
        core_rel <= wbyte[uepo_core_rst_bit]; // R15
      end
      usb_core_rst_n <= core_rel;
    end
  end

  uepo_osc_gate u_osc (
    .pclk(pclk),
    .presetn(presetn),
    .pd_enable(pd_en),
    .pd_control(pd_ctl),
    .osc_select(sync_b[0]),
    .cpu_stop(sync_b[1]),
    .cpu_subclk(sync_b[2]),
    .osc_run(osc_run)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: write one to clear, new event wins
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_acc && hit(paddr, uepo_irq_stat_addr)) begin
      next_irq_stat = irq_stat & ~wbyte[2:0];
    end
    if (ep_valid && rx_good) begin
      next_irq_stat[uepo_irq_rx_bit] = 1'b1;
    end
    if (ep_valid && host_ack) begin
      next_irq_stat[uepo_irq_ack_bit] = 1'b1;
    end
    if (|err_seen) begin
      next_irq_stat[uepo_irq_err_bit] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= uepo_irq_reset;
      irq_mask <= uepo_irq_reset;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_acc && hit(paddr, uepo_irq_mask_addr)) begin
        irq_mask <= wbyte[2:0];
      end
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux; data registered in setup, one wait-free access phase
  always_comb begin
    next_prdata = 32'h0;
    known = 1'b1;
    if (hit(paddr, uepo_endpoint_three_status_addr)) begin
      next_prdata[1:0] = ep_valid ? {tx_rdy, rx_rdy} : 2'h0; // R01 R06
    end else if (hit(paddr, uepo_usb_packet_error_flags_addr)) begin
      next_prdata[3:0] = err_flags; // R07
    end else if (hit(paddr, uepo_oscillator_powerdown_test_addr)) begin
      next_prdata[2:1] = {pd_en, pd_ctl};
    end else if (hit(paddr, uepo_ctrl_addr)) begin
      next_prdata[0] = core_rel;
    end else if (hit(paddr, uepo_irq_stat_addr)) begin
      next_prdata[2:0] = irq_stat;
    end else if (hit(paddr, uepo_irq_mask_addr)) begin
      next_prdata[2:0] = irq_mask;
    end else begin
      known = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rd_acc) begin
        prdata <= next_prdata;
      end
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint three flags, lock and handshake
  a_rx_lock: assert property (@(posedge pclk) disable iff (!presetn) // R02
    (ep_valid && rx_good && !usb_bus_reset) |=> rx_rdy ##1 !rx_enable)
    else $error("receive ready not set");
  a_rx_keep: assert property (@(posedge pclk) disable iff (!presetn) // R02
    (rx_rdy && !usb_bus_reset
     && !(wr_acc && hit(paddr, uepo_endpoint_three_status_addr) && wbyte[uepo_rx_rdy_bit]))
    |=> rx_rdy)
    else $error("receive lock dropped");
  a_rx_clear: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (wr_acc && hit(paddr, uepo_endpoint_three_status_addr) && wbyte[uepo_rx_rdy_bit] && !rx_good)
    |=> !rx_rdy)
    else $error("receive ready not cleared");
  a_rx_unlock: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (ep_valid && !rx_rdy) |=> rx_enable)
    else $error("receive not enabled");
  a_rx_ack: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (ep_valid && rx_token && !rx_rdy && !in_token) |=> handshake == uepo_ack)
    else $error("open endpoint not acked");
  a_tx_set: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (wr_acc && hit(paddr, uepo_endpoint_three_status_addr) && wbyte[uepo_tx_rdy_bit] && !host_ack
     && !usb_bus_reset) |=> tx_rdy)
    else $error("transmit ready not set");
  a_tx_keep: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (tx_rdy && !host_ack && !usb_bus_reset) |=> tx_rdy)
    else $error("transmit ready dropped");
  a_tx_allow: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (ep_valid && tx_rdy) |=> tx_enable)
    else $error("transmit not enabled");
  a_tx_ack: assert property (@(posedge pclk) disable iff (!presetn) // R05
    (ep_valid && host_ack && !usb_bus_reset) |=> !tx_rdy ##1 !tx_enable)
    else $error("transmit ready not cleared");
  a_zero_write: assert property (@(posedge pclk) disable iff (!presetn) // R17
    (wr_acc && hit(paddr, uepo_endpoint_three_status_addr) && wbyte[1:0] == 2'h0 && !rx_good
     && !host_ack && !usb_bus_reset) |=> $stable({rx_rdy, tx_rdy}))
    else $error("zero write changed flags");
  a_nak_locked: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (ep_valid && in_token && !tx_rdy) |=> handshake == uepo_nak)
    else $error("locked endpoint not naked");
  a_rx_nak: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (ep_valid && rx_token && rx_rdy) |=> handshake == uepo_nak)
    else $error("full endpoint not naked");
  a_ep_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R01
    !ep_valid |=> (!rx_enable && !tx_enable && handshake == uepo_idle))
    else $error("unconfigured endpoint active");
  a_ep_ignore: assert property (@(posedge pclk) disable iff (!presetn) // R01
    (!ep_valid && !usb_bus_reset && !(wr_acc && hit(paddr, uepo_endpoint_three_status_addr)))
    |=> ($stable(rx_rdy) && $stable(tx_rdy)))
    else $error("unconfigured endpoint flag moved");
  a_ep_read_mask: assert property (@(posedge pclk) disable iff (!presetn) // R01
    (rd_acc && hit(paddr, uepo_endpoint_three_status_addr) && !ep_valid) |=> prdata == 32'h0)
    else $error("unconfigured endpoint read nonzero");
  a_ep_upper: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (rd_acc && hit(paddr, uepo_endpoint_three_status_addr)) |=> prdata[31:2] == 30'h0)
    else $error("status upper bits nonzero");
  a_bus_reset: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (usb_bus_reset && !(wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr)))
    |=> (!rx_rdy && !tx_rdy && $stable(pd_en)))
    else $error("bus reset handling wrong");

  // Packet error flags
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R07
    (!sop_seen && !usb_bus_reset)
    |=> err_flags == ($past(err_flags) | $past(err_seen)))
    else $error("error flag lost or invented");
  a_err_sop_keep: assert property (@(posedge pclk) disable iff (!presetn) // R08
    (sop_seen && !usb_bus_reset) |=> err_flags == $past(err_seen))
    else $error("error at start of packet wrong");
  a_sop_clear: assert property (@(posedge pclk) disable iff (!presetn) // R08
    (sop_seen && err_seen == 4'h0) |=> err_flags == 4'h0)
    else $error("error flags not cleared");
  a_err_bus: assert property (@(posedge pclk) disable iff (!presetn) // R07
    usb_bus_reset |=> err_flags == 4'h0)
    else $error("error flags kept over bus reset");
  a_err_ro: assert property (@(posedge pclk) disable iff (!presetn) // R17
    (wr_acc && hit(paddr, uepo_usb_packet_error_flags_addr) && !sop_seen && !usb_bus_reset
     && err_seen == 4'h0) |=> $stable(err_flags))
    else $error("error flags written");
  a_err_upper: assert property (@(posedge pclk) disable iff (!presetn) // R07
    (rd_acc && hit(paddr, uepo_usb_packet_error_flags_addr)) |=> prdata[31:4] == 28'h0)
    else $error("error upper bits nonzero");

  // Oscillator test byte and core release
  a_osc_bus_keep: assert property (@(posedge pclk) disable iff (!presetn) // R09
    (usb_bus_reset && !(wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr)))
    |=> $stable(pd_ctl))
    else $error("bus reset changed power down control");
  a_pd_en_set: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr) && wbyte[uepo_pd_en_bit]) |=> pd_en)
    else $error("power down enable not set");
  a_pd_en_clr: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr) && !wbyte[uepo_pd_en_bit]) |=> !pd_en)
    else $error("power down enable not cleared");
  a_pd_ctl_set: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr) && wbyte[uepo_pd_ctl_bit]) |=> pd_ctl)
    else $error("power down control not set");
  a_pd_ctl_clr: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (wr_acc && hit(paddr, uepo_oscillator_powerdown_test_addr) && !wbyte[uepo_pd_ctl_bit]) |=> !pd_ctl)
    else $error("power down control not cleared");
  a_pd_ctl_run: assert property (@(posedge pclk) disable iff (!presetn) // R10
    pd_ctl |=> osc_run)
    else $error("oscillator stopped with control one");
  a_pd_off_run: assert property (@(posedge pclk) disable iff (!presetn) // R11
    !pd_en |=> osc_run)
    else $error("oscillator stopped without enable");
  a_core_hold: assert property (@(posedge pclk) disable iff (!presetn) // R15
    !core_rel |=> !usb_core_rst_n)
    else $error("core released early");
  a_core_release: assert property (@(posedge pclk) disable iff (!presetn) // R15
    core_rel |=> usb_core_rst_n)
    else $error("core not released");

  // Interrupt and bus response
  a_irq_rx: assert property (@(posedge pclk) disable iff (!presetn)
    (ep_valid && rx_good) |=> irq_stat[uepo_irq_rx_bit])
    else $error("receive interrupt not set");
  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_mask == 3'h0) |=> !irq)
    else $error("masked interrupt raised");
  a_err_resp: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");
endmodule
`default_nettype wire

// File: uepo_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uepo_host_model (
  input wire logic pclk, // Clock
  input wire logic [1:0] handshake, // Device answer
  output logic rx_good, // Good OUT packet
  output logic host_ack, // ACK of IN data
  output logic rx_token, // OUT data for ep3
  output logic in_token, // IN token for ep3
  output logic sop_seen, // Start of packet
  output logic [3:0] err_seen, // Error pulses
  output logic usb_bus_reset // Bus reset
);
  import uepo_pkg::*;
  initial begin
    {rx_good, host_ack, rx_token, in_token, sop_seen, err_seen, usb_bus_reset} = '0;
  end
  ////////////////////////////////////////////////////////////////
  // One-cycle events: 0 good, 1 ack, 2 sop, 3 errors, 4 bus reset
  task automatic pulse(input int k, input logic [3:0] e);
    @(posedge pclk);
    rx_good <= (k == 0);
    host_ack <= (k == 1);
    sop_seen <= (k == 2);
    err_seen <= (k == 3) ? e : 4'h0;
    usb_bus_reset <= (k == 4);
    @(posedge pclk);
    {rx_good, host_ack, sop_seen, err_seen, usb_bus_reset} <= '0;
  endtask
  ////////////////////////////////////////////////////////////////
  // Token, then first non-idle answer within a short window
  task automatic token(input logic is_in, output logic [1:0] hs);
    @(posedge pclk);
    rx_token <= !is_in;
    in_token <= is_in;
    @(posedge pclk);
    rx_token <= 1'b0;
    in_token <= 1'b0;
    hs = uepo_idle;
    repeat (4) begin
      @(posedge pclk);
      if (hs === uepo_idle && handshake !== uepo_idle) hs = handshake;
    end
  endtask
endmodule
`default_nettype wire

// File: usb_ep3_status_and_osc_powerdown_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module usb_ep3_status_and_osc_powerdown_tb_top;
  import uepo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, v;
  logic osc_sel, cpu_stop, cpu_sub, irq, rx_en, tx_en, core_n, osc_run;
  logic bus_rst, rx_good, host_ack, rx_tok, in_tok, sop;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ep_type, hs, hs_got;
  logic [3:0] err_seen, m;
  logic [4:0] o;
  int err_total, n_checks;
  uepo_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_bus_reset(bus_rst), .ep3_type(ep_type), .rx_good(rx_good),
    .host_ack(host_ack), .rx_token(rx_tok), .in_token(in_tok), .sop_seen(sop),
    .err_seen(err_seen), .osc_select_pin(osc_sel), .cpu_stop_pin(cpu_stop),
    .cpu_subclk_pin(cpu_sub), .handshake(hs), .rx_enable(rx_en), .tx_enable(tx_en),
    .usb_core_rst_n(core_n), .osc_run(osc_run), .irq(irq));
  uepo_host_model host_u (.pclk(pclk), .handshake(hs), .rx_good(rx_good),
    .host_ack(host_ack), .rx_token(rx_tok), .in_token(in_tok), .sop_seen(sop),
    .err_seen(err_seen), .usb_bus_reset(bus_rst));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until pready is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    // Register index to aligned word address; only the watchdog ends a wait
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a[13:0], 2'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  function automatic logic exp_osc(input logic [4:0] c);
    return !(c[4] & !c[3] & c[2] & (c[1] | c[0]));
  endfunction
  // Fields: en, ctl, select, stop, subclock
  task osc_case(input logic [4:0] c);
    {osc_sel, cpu_stop, cpu_sub} <= c[2:0];
    wr(uepo_oscillator_powerdown_test_addr, {29'h0, c[4:3], 1'b0});
    repeat (6) @(posedge pclk);
    chk("osc_run", exp_osc(c), osc_run);
    rdc("osc_rd", uepo_oscillator_powerdown_test_addr, {29'h0, c[4:3], 1'b0});
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {osc_sel, cpu_stop, cpu_sub} = 3'h0;
    ep_type = uepo_ep_bulk;
    err_total = 0;
    n_checks = 0;
    void'($urandom(66));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("osc_rst", 1, osc_run);
    chk("core_rst", 0, core_n);
    rdc("ep3_rst", uepo_endpoint_three_status_addr, 0);
    rdc("err_rst", uepo_usb_packet_error_flags_addr, 0);
    rdc("osc_rst", uepo_oscillator_powerdown_test_addr, 0);
    wr(uepo_ctrl_addr, 1);
    repeat (2) @(posedge pclk);
    chk("core_rel", 1, core_n);
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      ep_type <= t[1:0];
      v = (t >= 2);
      // Flags written while unconfigured would leak into the next pass
      host_u.pulse(4, 4'h0);
      host_u.pulse(0, 4'h0);
      rdc("rx_set", uepo_endpoint_three_status_addr, v);
      host_u.token(1'b0, hs_got);
      if (v) chk("rx_nak", uepo_nak, hs_got);
      wr(uepo_endpoint_three_status_addr, 0);
      rdc("rx_zero", uepo_endpoint_three_status_addr, v);
      wr(uepo_endpoint_three_status_addr, 1);
      rdc("rx_clr", uepo_endpoint_three_status_addr, 0);
      if (v) chk("rx_en", 1, rx_en);
      host_u.token(1'b0, hs_got);
      if (v) chk("rx_ack", uepo_ack, hs_got);
      host_u.token(1'b1, hs_got);
      if (v) chk("tx_nak", uepo_nak, hs_got);
      wr(uepo_endpoint_three_status_addr, 2);
      rdc("tx_set", uepo_endpoint_three_status_addr, v ? 2 : 0);
      if (v) chk("tx_en", 1, tx_en);
      host_u.pulse(1, 4'h0);
      rdc("tx_ack", uepo_endpoint_three_status_addr, 0);
      if (v) chk("tx_lock", 0, tx_en);
    end
    $display("test endpoint done");
    repeat (4) begin
      m = 4'($urandom_range(15, 1));
      host_u.pulse(3, m);
      rdc("err_set", uepo_usb_packet_error_flags_addr, {28'h0, m});
      wr(uepo_usb_packet_error_flags_addr, 32'hff);
      rdc("err_ro", uepo_usb_packet_error_flags_addr, {28'h0, m});
      host_u.pulse(2, 4'h0);
      rdc("err_sop", uepo_usb_packet_error_flags_addr, 0);
    end
    $display("test errors done");
    host_u.pulse(0, 4'h0);
    host_u.pulse(3, 4'h5);
    wr(uepo_oscillator_powerdown_test_addr, 6);
    host_u.pulse(4, 4'h0);
    rdc("ep3_bus", uepo_endpoint_three_status_addr, 0);
    rdc("err_bus", uepo_usb_packet_error_flags_addr, 0);
    rdc("osc_bus", uepo_oscillator_powerdown_test_addr, 6);
    $display("test bus reset done");
    osc_case(5'b10110);
    osc_case(5'b10101);
    osc_case(5'b10100);
    osc_case(5'b00111);
    for (int i = 0; i < 12; i++) begin
      o = 5'($urandom);
      osc_case(o);
    end
    $display("test oscillator done");
    wr(uepo_irq_stat_addr, 7);
    host_u.pulse(0, 4'h0);
    rdc("irq_st", uepo_irq_stat_addr, 1);
    wr(uepo_irq_mask_addr, 0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 0, irq);
    wr(uepo_irq_mask_addr, 7);
    repeat (2) @(posedge pclk);
    chk("irq_mask", 1, irq);
    wr(uepo_irq_stat_addr, 1);
    rdc("irq_clr", uepo_irq_stat_addr, 0);
    chk("irq_off", 0, irq);
    host_u.pulse(3, 4'h2);
    host_u.pulse(1, 4'h0);
    rdc("irq_ev", uepo_irq_stat_addr, 6);
    chk("irq_on", 1, irq);
    apb(1'b0, 16'h1a50, 32'h0);
    chk("slverr", 1, err);
    chk("unm_rd", 0, rd);
    $display("test interrupt and map done");
    close_out();
  end
endmodule
`default_nettype wire
